// >>> hdl/core_pkg.sv
/*
  Shared constants, carrier structs and the adder function for the 12-bit
  instruction decoder and its return stack.
  Assumes one clock domain; all timing is in core_clk cycles.
*/
package core_pkg;

  localparam int INSTR_W     = 12;
  localparam int DATA_W      = 8;
  localparam int PC_W        = 11;
  localparam int STACK_DEPTH = 4;

  // one instruction cycle is four oscillator periods
  localparam int CYCLE_PHASES = 4;

  // reset values
  localparam logic [PC_W-1:0] PC_RESET      = 11'h000;
  localparam logic [PC_W-1:0] PC_RESET_NEXT = 11'h001;

  // fixed encodings
  localparam logic [INSTR_W-1:0] OP_NOP = 12'h000;

  // file addresses with side effects
  localparam logic [4:0] FILE_TIMER  = 5'h01;
  localparam logic [4:0] FILE_PORT_A = 5'h06;

  // low bits of the 0000 000x xxxx control group: five per opcode, three for the first direction select
  localparam logic [4:0] CTL_SLEEP     = 5'h03;
  localparam logic [4:0] CTL_WDT_KICK  = 5'h04;
  localparam logic [4:0] CTL_RETURN    = 5'h1E;
  localparam logic [4:0] CTL_RETURN_IRQ = 5'h1F;
  localparam logic [2:0] DIR_SEL_FIRST = 3'h5;

  // register port offsets
  localparam logic [2:0] REG_ACC    = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_BANK   = 3'h2;
  localparam logic [2:0] REG_PC_LO  = 3'h3;
  localparam logic [2:0] REG_PC_HI  = 3'h4;

  // status field positions
  localparam int ST_CARRY  = 0;
  localparam int ST_HALF   = 1;
  localparam int ST_ZERO   = 2;
  localparam int ST_SLEEP  = 3;
  localparam int ST_EXPIRY = 4;
  localparam int ST_PAGE   = 5;

  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_READ  = 2'b01,
    PH_EXEC  = 2'b10,
    PH_IDLE  = 2'b11
  } phase_t;

  typedef struct packed {
    logic [4:0]        addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
  } file_req_t;

  typedef struct packed {
    logic [2:0]        sel;
    logic [DATA_W-1:0] data;
    logic              we;
  } dir_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] res;
    logic              c;
    logic              dc;
  } alu_out_t;

  typedef struct packed {
    phase_t              phase;
    logic [INSTR_W-1:0]  ir;
    logic                flush;
    logic [PC_W-1:0]     program_counter;
    logic [PC_W-1:0]     fetch_addr;
    logic [DATA_W-1:0]   acc;
    logic [DATA_W-1:0]   opnd;
    logic                carry;
    logic                half_carry;
    logic                zero;
    logic                expiry_flag_n;
    logic                sleep_flag_n;
    logic [1:0]          page;
    logic [2:0]          bank;
    logic                global_irq_enable;
    file_req_t           file;
    dir_req_t            dir;
    logic                pre_clr;
    logic                wdt_clr;
    logic                sleep_go;
    logic [DATA_W-1:0]   rdata;
    logic [DATA_W-1:0]   pins_s1;
    logic [DATA_W-1:0]   pins_s2;
  } core_state_t;

  localparam core_state_t CORE_RESET = '{
    phase:           PH_FETCH,
    program_counter: PC_RESET_NEXT,
    fetch_addr:      PC_RESET,
    expiry_flag_n:   1'b1,
    sleep_flag_n:    1'b1,
    default:         '0
  };

  typedef struct packed {
    logic [STACK_DEPTH-1:0][PC_W-1:0] ent;
  } stack_state_t;

  function automatic alu_out_t alu_add(input logic [DATA_W-1:0] a,
                                       input logic [DATA_W-1:0] b,
                                       input logic              cin);
    logic [DATA_W:0] sum;
    logic [4:0]      lo;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    lo  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    alu_add.res = sum[DATA_W-1:0];
    alu_add.c   = sum[DATA_W];
    alu_add.dc  = lo[4];
  endfunction : alu_add

endpackage : core_pkg

// >>> hdl/return_stack.sv
/*
  Four-entry hardware return stack; the top entry is a register.
  Assumes push and pop never arrive together and come on core_clk.
*/
`timescale 1ns/1ns
module return_stack
  import core_pkg::*;
(
  input  wire logic            core_clk,   // core clock
  input  wire logic            rst,        // synchronous reset
  input  wire logic            ce,         // clock enable
  input  wire logic            push,       // push one address
  input  wire logic            pop,        // drop the top entry
  input  wire logic [PC_W-1:0] push_data,  // address to push
  output logic      [PC_W-1:0] stack_head  // registered top entry
);

  stack_state_t r;
  stack_state_t s;

  // overflow silently loses the deepest entry, underflow repeats it
  always_comb begin
    s = r;
    if (push) begin
      for (int i = STACK_DEPTH - 1; i > 0; i--) begin
        s.ent[i] = r.ent[i-1];
      end
      s.ent[0] = push_data;
    end else if (pop) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        s.ent[i] = r.ent[i+1];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= s;
    end
  end

  assign stack_head = r.ent[0];

endmodule : return_stack

// >>> hdl/core_exec.sv
/*
  Instruction decoder and executor: fetches 12-bit words, runs each in a
  four-phase instruction cycle, drives file register and direction writes.
  Assumes program memory and file registers answer combinationally on
  core_clk; port_a_pins comes from outside and is synchronised here.
*/
`timescale 1ns/1ns
module core_exec
  import core_pkg::*;
(
  input  wire logic               core_clk,            // core clock, 10 MHz
  input  wire logic               rst,                 // synchronous reset, high
  input  wire logic               ce,                  // clock enable, freezes all
  input  wire logic [INSTR_W-1:0] instr_word,          // word at prog_addr
  input  wire logic [DATA_W-1:0]  file_rdata,          // file data at file_req.addr
  input  wire logic [DATA_W-1:0]  port_a_pins,         // pin levels, asynchronous
  input  wire logic               prescaler_on_timer,  // prescaler assigned to timer
  input  wire logic               prescaler_on_wdog,   // prescaler assigned to watchdog
  input  wire logic [2:0]         reg_addr,            // register port address
  input  wire logic [DATA_W-1:0]  reg_wdata,           // register port write data
  input  wire logic               reg_wr,              // register write strobe
  input  wire logic               reg_rd,              // register read strobe
  output logic      [DATA_W-1:0]  reg_rdata,           // read data, cycle after strobe
  output logic      [PC_W-1:0]    prog_addr,           // program fetch address
  output file_req_t               file_req,            // file address, data, write
  output logic      [2:0]         bank_select,         // bank select register
  output dir_req_t                dir_req,             // direction latch write
  output logic                    timer_prescale_clr,  // prescaler clear pulse
  output logic                    watchdog_clear,      // watchdog kick pulse
  output logic                    wdog_prescale_clr,   // watchdog prescaler clear
  output logic                    sleep_enter,         // standby request pulse
  output logic                    global_irq_enable    // interrupt enable bit
);

  core_state_t     r;
  core_state_t     s;
  logic            push;
  logic            pop;
  logic [PC_W-1:0] stack_head;
  logic            wdog_pre_clr_r;

  return_stack u_stack (
    .core_clk   (core_clk),
    .rst        (rst),
    .ce         (ce),
    .push       (push),
    .pop        (pop),
    .push_data  (r.fetch_addr),
    .stack_head (stack_head)
  );

  always_comb begin
    logic [DATA_W-1:0] res;
    logic              wr_res;
    logic              to_file;
    logic [DATA_W-1:0] bmask;
    logic              tbit;
    logic [DATA_W-1:0] k8;
    alu_out_t          a;
    res     = '0;
    wr_res  = 1'b0;
    to_file = 1'b0;
    k8      = r.ir[7:0];
    bmask   = 8'h01 << r.ir[7:5];
    tbit    = |(r.opnd & bmask);
    a       = alu_add(8'h00, 8'h00, 1'b0);
    push    = 1'b0;
    pop     = 1'b0;

    s            = r;
    s.file.we    = 1'b0;
    s.dir.we     = 1'b0;
    s.pre_clr    = 1'b0;
    s.wdt_clr    = 1'b0;
    s.sleep_go   = 1'b0;
    s.pins_s1    = port_a_pins;
    s.pins_s2    = r.pins_s1;

    // register port; execution below overrides flags it also touches
    s.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_ACC:    s.rdata = r.acc;
        REG_STATUS: s.rdata = {1'b0, r.page, r.expiry_flag_n, r.sleep_flag_n,
                               r.zero, r.half_carry, r.carry};
        REG_BANK:   s.rdata = {5'h00, r.bank};
        REG_PC_LO:  s.rdata = r.program_counter[7:0];
        REG_PC_HI:  s.rdata = {5'h00, r.program_counter[PC_W-1:8]};
        default:    s.rdata = '0;
      endcase
    end
    if (reg_wr) begin
      case (reg_addr)
        REG_STATUS: begin
          s.page       = reg_wdata[ST_PAGE+1:ST_PAGE];
          s.zero       = reg_wdata[ST_ZERO];
          s.half_carry = reg_wdata[ST_HALF];
          s.carry      = reg_wdata[ST_CARRY];
        end
        REG_BANK: s.bank = reg_wdata[2:0];
        default:  ;
      endcase
    end

    case (r.phase)
      PH_FETCH: begin
        // a flushed slot runs as a no-op, giving the second cycle
        s.ir              = r.flush ? OP_NOP : instr_word;
        s.flush           = 1'b0;
        s.fetch_addr      = r.program_counter;
        s.program_counter = PC_W'(r.program_counter + 1'b1);
        s.file.addr       = instr_word[4:0];
        s.phase           = PH_READ;
      end
      PH_READ: begin
        // pins, not latches, so inputs driven low read back as 0
        s.opnd  = (r.file.addr == FILE_PORT_A) ? r.pins_s2 : file_rdata;
        s.phase = PH_EXEC;
      end
      PH_EXEC: begin
        s.phase = PH_IDLE;
        case (r.ir[11:10])
          2'b00: begin
            case (r.ir[9:6])
              4'h0: begin
                if (r.ir[5]) begin
                  res     = r.acc;
                  wr_res  = 1'b1;
                  to_file = 1'b1;
                end else if (r.ir[4:3] == 2'b10) begin
                  s.bank = r.ir[2:0];
                end else begin
                  case (r.ir[4:0])
                    CTL_SLEEP: begin
                      s.expiry_flag_n = 1'b1;
                      s.sleep_flag_n  = 1'b0;
                      s.sleep_go      = 1'b1;
                    end
                    CTL_WDT_KICK: begin
                      s.wdt_clr       = 1'b1;
                      s.expiry_flag_n = 1'b1;
                      s.sleep_flag_n  = 1'b1;
                    end
                    CTL_RETURN: begin
                      pop               = 1'b1;
                      s.program_counter = {stack_head[PC_W-1:9], 1'b0,
                                           stack_head[7:0]};
                      s.flush           = 1'b1;
                    end
                    CTL_RETURN_IRQ: begin
                      pop                 = 1'b1;
                      s.program_counter   = {stack_head[PC_W-1:9], 1'b0,
                                             stack_head[7:0]};
                      s.global_irq_enable = 1'b1;
                      s.flush             = 1'b1;
                    end
                    default: begin
                      if (r.ir[4:3] == 2'b00 && r.ir[2:0] >= DIR_SEL_FIRST) begin
                        s.dir.we   = 1'b1;
                        s.dir.sel  = r.ir[2:0];
                        s.dir.data = r.acc;
                      end
                    end
                  endcase
                end
              end
              4'h1: begin
                if (r.ir[5]) begin
                  res     = '0;
                  wr_res  = 1'b1;
                  to_file = 1'b1;
                  s.zero  = 1'b1;
                end else if (r.ir[4:0] == 5'h00) begin
                  s.acc  = '0;
                  s.zero = 1'b1;
                end
              end
              4'h2, 4'h7: begin
                // subtract is f + ~w + 1, so carry means no borrow
                a = (r.ir[9:6] == 4'h7) ? alu_add(r.acc, r.opnd, 1'b0)
                                        : alu_add(r.opnd, ~r.acc, 1'b1);
                res          = a.res;
                wr_res       = 1'b1;
                s.carry      = a.c;
                s.half_carry = a.dc;
                s.zero       = (a.res == 8'h00);
              end
              4'h3, 4'hA: begin
                a      = alu_add(r.opnd, (r.ir[9:6] == 4'hA) ? 8'h01 : 8'hFF, 1'b0);
                res    = a.res;
                wr_res = 1'b1;
                s.zero = (a.res == 8'h00);
              end
              4'hB, 4'hF: begin
                a       = alu_add(r.opnd, (r.ir[9:6] == 4'hF) ? 8'h01 : 8'hFF, 1'b0);
                res     = a.res;
                wr_res  = 1'b1;
                s.flush = (a.res == 8'h00);
              end
              4'h4, 4'h5, 4'h6, 4'h9: begin
                case (r.ir[9:6])
                  4'h4:    res = r.acc | r.opnd;
                  4'h5:    res = r.acc & r.opnd;
                  4'h6:    res = r.acc ^ r.opnd;
                  default: res = ~r.opnd;
                endcase
                wr_res = 1'b1;
                s.zero = (res == 8'h00);
              end
              4'h8: begin
                res    = r.opnd;
                wr_res = 1'b1;
                s.zero = (res == 8'h00);
              end
              4'hC: begin
                res     = {r.carry, r.opnd[7:1]};
                wr_res  = 1'b1;
                s.carry = r.opnd[0];
              end
              4'hD: begin
                res     = {r.opnd[6:0], r.carry};
                wr_res  = 1'b1;
                s.carry = r.opnd[7];
              end
              4'hE: begin
                res    = {r.opnd[3:0], r.opnd[7:4]};
                wr_res = 1'b1;
              end
              default: ;
            endcase
            if (r.ir[9:6] != 4'h0 && r.ir[9:6] != 4'h1) begin
              to_file = r.ir[5];
            end
          end
          2'b01: begin
            case (r.ir[9:8])
              2'b00: begin
                res     = r.opnd & ~bmask;
                wr_res  = 1'b1;
                to_file = 1'b1;
              end
              2'b01: begin
                res     = r.opnd | bmask;
                wr_res  = 1'b1;
                to_file = 1'b1;
              end
              2'b10:   s.flush = ~tbit;
              default: s.flush = tbit;
            endcase
          end
          2'b10: begin
            s.flush = 1'b1;
            case (r.ir[9:8])
              2'b00: begin
                s.acc             = k8;
                pop               = 1'b1;
                s.program_counter = {stack_head[PC_W-1:9], 1'b0, stack_head[7:0]};
              end
              2'b01: begin
                push              = 1'b1;
                s.program_counter = {r.page, 1'b0, k8};
              end
              default: s.program_counter = {r.page, r.ir[8:0]};
            endcase
          end
          default: begin
            case (r.ir[9:8])
              2'b00:   s.acc = k8;
              2'b01:   s.acc = r.acc | k8;
              2'b10:   s.acc = r.acc & k8;
              default: s.acc = r.acc ^ k8;
            endcase
            if (r.ir[9:8] != 2'b00) begin
              s.zero = (s.acc == 8'h00);
            end
          end
        endcase
        if (wr_res) begin
          if (to_file) begin
            s.file.we    = 1'b1;
            s.file.wdata = res;
            s.pre_clr    = (r.file.addr == FILE_TIMER) && prescaler_on_timer;
          end else begin
            s.acc = res;
          end
        end
      end
      PH_IDLE: s.phase = PH_FETCH;
      default: s.phase = PH_FETCH;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= CORE_RESET;
    end else if (ce) begin
      r <= s;
    end
  end

  assign reg_rdata          = r.rdata;
  assign prog_addr          = r.fetch_addr;
  assign file_req           = r.file;
  assign bank_select        = r.bank;
  assign dir_req            = r.dir;
  assign timer_prescale_clr = r.pre_clr;
  assign watchdog_clear     = r.wdt_clr;
  assign wdog_prescale_clr  = wdog_pre_clr_r;
  assign sleep_enter        = r.sleep_go;
  assign global_irq_enable  = r.global_irq_enable;

  // own flop so the qualified clear leaves the block with no gate behind it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wdog_pre_clr_r <= 1'b0;
    end else if (ce) begin
      wdog_pre_clr_r <= s.wdt_clr & prescaler_on_wdog;
    end
  end

endmodule : core_exec

// >>> bench/core_exec_props.sv
/*
  Concurrent checks on the ports of core_exec, bound into it.
  Assumes one clock domain and ce high whenever the checks matter.
*/
`timescale 1ns/1ns
module core_exec_props
  import core_pkg::*;
(
  input wire logic              core_clk,            // core clock
  input wire logic              rst,                 // synchronous reset
  input wire logic              ce,                  // clock enable
  input wire logic              prescaler_on_timer,  // prescaler on timer
  input wire logic              prescaler_on_wdog,   // prescaler on watchdog
  input wire logic              reg_rd,              // read strobe
  input wire logic [DATA_W-1:0] reg_rdata,           // read data
  input wire logic [PC_W-1:0]   prog_addr,           // fetch address
  input wire file_req_t         file_req,            // file access
  input wire dir_req_t          dir_req,             // direction write
  input wire logic              timer_prescale_clr,  // timer prescaler clear
  input wire logic              watchdog_clear,      // watchdog kick
  input wire logic              wdog_prescale_clr,   // watchdog prescaler clear
  input wire logic              sleep_enter          // standby pulse
);
  default clocking cb @(posedge core_clk); endclocking
  // a frozen core stretches every phase, so ce low pauses the checks
  default disable iff (rst || !ce);

  chk_we_spacing: assert property (file_req.we |=> !file_req.we [*3])
    else $error("file write closer than one instruction cycle");
  chk_fetch_steady: assert property ($changed(prog_addr) |=> $stable(prog_addr) [*3])
    else $error("fetch address moved inside an instruction cycle");
  chk_dir_select: assert property (dir_req.we |-> dir_req.sel >= DIR_SEL_FIRST)
    else $error("direction write with a reserved select");
  chk_dir_spacing: assert property (dir_req.we |=> !dir_req.we [*3])
    else $error("direction write repeated");
  chk_timer_cause: assert property (file_req.we && file_req.addr == FILE_TIMER
      && $past(prescaler_on_timer) |-> timer_prescale_clr)
    else $error("timer write without prescaler clear");
  chk_timer_only: assert property (timer_prescale_clr
      |-> file_req.we && file_req.addr == FILE_TIMER)
    else $error("prescaler clear without timer write");
  chk_wdog_pair: assert property (wdog_prescale_clr
      == (watchdog_clear && $past(prescaler_on_wdog)))
    else $error("watchdog prescaler clear mismatch");
  chk_kick_pulse: assert property (watchdog_clear |=> !watchdog_clear [*3])
    else $error("watchdog kick longer than one pulse");
  chk_sleep_alone: assert property (sleep_enter
      |-> !file_req.we && !dir_req.we && !watchdog_clear)
    else $error("standby request beside another effect");
  chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");

  cov_file_write: cover property (file_req.we && file_req.addr == FILE_PORT_A);
  cov_dir_write: cover property (dir_req.we);
  cov_kick: cover property (wdog_prescale_clr);
  cov_sleep: cover property (sleep_enter);
endmodule : core_exec_props

bind core_exec core_exec_props u_core_exec_props (.core_clk, .rst, .ce, .prescaler_on_timer,
  .prescaler_on_wdog, .reg_rd, .reg_rdata, .prog_addr, .file_req, .dir_req,
  .timer_prescale_clr, .watchdog_clear, .wdog_prescale_clr, .sleep_enter);

// >>> bench/prog_file_model.sv
/*
  Program memory and file registers facing core_exec.
  Assumes the bench loads rom and fregs directly between runs.
*/
`timescale 1ns/1ns
module prog_file_model
  import core_pkg::*;
(
  input  wire logic               core_clk,          // core clock
  input  wire logic [PC_W-1:0]    prog_addr,         // fetch address
  output logic      [INSTR_W-1:0] instr_word,        // word at prog_addr
  input  wire file_req_t          file_req,          // file access
  output logic      [DATA_W-1:0]  file_rdata         // file data
);
  logic [INSTR_W-1:0] rom   [0:(1<<PC_W)-1];
  logic [DATA_W-1:0]  fregs [0:31];

  // combinational memory, as the core expects
  assign instr_word = rom[prog_addr];
  assign file_rdata = fregs[file_req.addr];

  always @(posedge core_clk) begin
    if (file_req.we === 1'b1) begin
      fregs[file_req.addr] <= file_req.wdata;
    end
  end
endmodule : prog_file_model

// >>> bench/core_exec_tb.sv
/*
  Self-checking bench: runs small programs through core_exec.
  Assumes ce high, prescaler on both until test_logic takes it off the watchdog, fixed port A pin pattern.
*/
`timescale 1ns/1ns
module core_exec_tb;
  import core_pkg::*;
  logic               core_clk, rst, ce, reg_wr, reg_rd, sleep_enter, global_irq_enable;
  logic               prescaler_on_timer, prescaler_on_wdog, timer_prescale_clr;
  logic               watchdog_clear, wdog_prescale_clr;
  logic [INSTR_W-1:0] instr_word;
  logic [DATA_W-1:0]  file_rdata, port_a_pins, reg_wdata, reg_rdata, got;
  logic [7:0]         n_dir, n_tmr, n_wdc, n_wpc, n_slp;
  logic [PC_W-1:0]    prog_addr;
  logic [2:0]         reg_addr, bank_select;
  file_req_t          file_req;
  dir_req_t           dir_req, dir_seen;
  int                 failures, num_checks;

  core_exec u_core_exec (.core_clk, .rst, .ce, .instr_word, .file_rdata, .port_a_pins,
    .prescaler_on_timer, .prescaler_on_wdog, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .prog_addr, .file_req, .bank_select, .dir_req, .timer_prescale_clr,
    .watchdog_clear, .wdog_prescale_clr, .sleep_enter, .global_irq_enable);
  prog_file_model u_prog_file_model (.core_clk, .prog_addr,
    .instr_word, .file_req, .file_rdata);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (dir_req.we === 1'b1) begin
      n_dir    <= n_dir + 8'h01;
      dir_seen <= dir_req;
    end
    if (timer_prescale_clr === 1'b1) n_tmr <= n_tmr + 8'h01;
    if (watchdog_clear === 1'b1) n_wdc <= n_wdc + 8'h01;
    if (wdog_prescale_clr === 1'b1) n_wpc <= n_wpc + 8'h01;
    if (sleep_enter === 1'b1) n_slp <= n_slp + 8'h01;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // reset held 16 cycles; program memory blanked to no-ops meanwhile
  task automatic start();
    rst <= 1'b1;
    for (int i = 0; i < (1 << PC_W); i++) u_prog_file_model.rom[i] = OP_NOP;
    for (int i = 0; i < 32; i++) u_prog_file_model.fregs[i] = 8'h00;
    {n_dir, n_tmr, n_wdc, n_wpc, n_slp} = '0;
    repeat (16) @(posedge core_clk);
  endtask : start

  task automatic put(input int a, input logic [INSTR_W-1:0] w);
    u_prog_file_model.rom[a] = w;
  endtask : put

  // first edge after release fetches address 0
  task automatic go(input int cycles);
    rst <= 1'b0;
    repeat (CYCLE_PHASES * cycles) @(posedge core_clk);
  endtask : go

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
    @(posedge core_clk);
  endtask : rd

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic test_arith();
    start();
    u_prog_file_model.fregs[8] = 8'hC8;
    put(0, 12'hC3C); put(1, 12'h1E8); put(2, 12'h308); put(3, 12'h0A8);
    put(4, 12'h3A8); put(5, 12'hFFF); put(6, 12'hE00);
    go(7);
    rd(REG_ACC, got); check("acc", 8'h00, got);
    rd(REG_STATUS, got); check("status", 8'h1E, got);
    check("file8", 8'h28, u_prog_file_model.fregs[8]);
    $display("test arith done");
  endtask : test_arith

  task automatic test_branch();
    start();
    u_prog_file_model.fregs[9] = 8'h01;
    put(0, 12'hC01); put(1, 12'h2E9); put(2, 12'h015); put(3, 12'hB10);
    put(4, 12'h016); put('h110, 12'h920); put('h20, 12'h899); put('h11, 12'hF0F);
    put('h12, 12'h930); put('h30, 12'h01F);
    go(15);
    rd(REG_PC_LO, got); check("pc low", 8'h15, got);
    rd(REG_PC_HI, got); check("pc high", 8'h00, got);
    rd(REG_ACC, got); check("acc", 8'h96, got);
    check("file9", 8'h00, u_prog_file_model.fregs[9]);
    check("bank", 8'h00, {5'h00, bank_select});
    check("irq enable", 8'h01, {7'h00, global_irq_enable});
    $display("test branch done");
  endtask : test_branch

  task automatic test_bits();
    start();
    u_prog_file_model.fregs[5] = 8'hF0;
    put(0, 12'h565); put(1, 12'h4E5); put(2, 12'h506); put(3, 12'hC3E);
    put(4, 12'h002); put(5, 12'h006); put(6, 12'h013); put(7, 12'h7C5);
    put(8, 12'h017); put(9, 12'h021); put(10, 12'h004); put(11, 12'h003);
    // one spare cycle so the sleep pulse counter has settled
    go(13);
    check("file5", 8'h78, u_prog_file_model.fregs[5]);
    check("file6", 8'hA5, u_prog_file_model.fregs[6]);
    check("dir count", 8'h01, n_dir);
    check("dir sel", 8'h06, {5'h00, dir_seen.sel});
    check("dir data", 8'h3E, dir_seen.data);
    check("bank", 8'h03, {5'h00, bank_select});
    check("timer file", 8'h3E, u_prog_file_model.fregs[1]);
    check("timer clear", 8'h01, n_tmr);
    check("kick", 8'h01, n_wdc);
    check("kick prescaler", 8'h01, n_wpc);
    check("sleep", 8'h01, n_slp);
    rd(REG_STATUS, got); check("status", 8'h10, got);
    $display("test bits done");
  endtask : test_bits

  task automatic test_logic();
    start();
    prescaler_on_wdog <= 1'b0;
    u_prog_file_model.fregs[10] = 8'h5A;
    put(0, 12'hC0F); put(1, 12'h26A); put(2, 12'h14A); put(3, 12'h1AA);
    put(4, 12'h34A); put(5, 12'h60A); put(6, 12'hC77); put(7, 12'h0EA);
    put(8, 12'h004);
    go(9);
    rd(REG_ACC, got); check("acc", 8'h40, got);
    rd(REG_STATUS, got); check("status", 8'h19, got);
    check("file10", 8'h9F, u_prog_file_model.fregs[10]);
    check("kick", 8'h01, n_wdc);
    check("kick prescaler", 8'h00, n_wpc);
    $display("test logic done");
  endtask : test_logic

  task automatic test_regs();
    start();
    go(1);
    wr(REG_STATUS, 8'h67);
    rd(REG_STATUS, got); check("status", 8'h7F, got);
    wr(REG_BANK, 8'hFD);
    rd(REG_BANK, got); check("bank reg", 8'h05, got);
    check("bank out", 8'h05, {5'h00, bank_select});
    wr(REG_ACC, 8'hAA);
    rd(REG_ACC, got); check("acc", 8'h00, got);
    rd(3'h7, got); check("unmapped", 8'h00, got);
    $display("test regs done");
  endtask : test_regs

  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  initial begin
    {rst, ce, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, 2'b00, 3'h0, 8'h00};
    {prescaler_on_timer, prescaler_on_wdog, port_a_pins} = {2'b11, 8'hA5};
    {failures, num_checks} = '0;
    test_arith();
    test_branch();
    test_bits();
    test_logic();
    test_regs();
    results();
  end

  // tests take well under 1000 cycles; this leaves ample margin
  initial begin
    #(20000 * 100);
    failures++;
    results();
  end
endmodule : core_exec_tb
